// >>> ldo_good_model.sv
/*
  Regulator power-good model for the register bank bench.
  Assumes enables come from the bank, one clock, sync active-low reset.
*/
module ldo_good_model (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_en_a,
    input  wire logic i_en_b,
    output logic      o_good_a,
    output logic      o_good_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ramp_a_r;
    logic [3:0] ramp_b_r;
    // ======================================================
    // soft-start: good after 8 enabled cycles, lost at once
    always_ff @(posedge i_clk) begin
        ramp_a_r <= (!i_rst_b || !i_en_a) ? 4'h0 : ramp_a_r + {3'h0, !ramp_a_r[3]};
        ramp_b_r <= (!i_rst_b || !i_en_b) ? 4'h0 : ramp_b_r + {3'h0, !ramp_b_r[3]};
    end
    assign o_good_a = ramp_a_r[3];
    assign o_good_b = ramp_b_r[3];
endmodule : ldo_good_model

// >>> pmic_ldo_charger_regs.sv
/*
  Byte-wide control and status register bank for two low-noise regulators,
  two keep-alive regulators and the battery charger controls.
  Assumes a serial management front end on i_clk that presents one register
  access at a time as address, data and a one-cycle strobe; analog status
  lines arrive asynchronously and are filtered here.
*/
//
// Function
// - six-bit level field, upper two bits reserved
// - control bit 7 switches regulator on/off
// - bleed bit discharges output while regulator off
// - control bit 1 allows regulator fault interrupts
// - control bit 0 reads power-good, read-only
// - keep-alive bit 7 enables first regulator
// - keep-alive bit 6 enables second; rest reserved
// - charger bit 7 suspends charging until cleared
// - bits 5:4 select total timer; bit 6 reserved
// - bits 3:2 select precondition timer limit
// - bit 1 selects charge current
// - bit 0 selects input over-voltage threshold
// - status bit arms and reports time-out interrupt
// - time-out status valid only with input in window
// - total time-out enable bit raises interrupt
// - precondition time-out enable bit raises interrupt
`include "pmic_ldo_charger_regs_map.svh"

module pmic_ldo_charger_regs (
    input  wire logic                              i_clk,
    input  wire logic                              i_rst_b,
    input  wire logic [7:0]                        i_reg_addr,
    input  wire logic [7:0]                        i_reg_wdata,
    input  wire logic                              i_reg_wr,
    input  wire logic                              i_reg_rd,
    output logic      [7:0]                        o_reg_rdata,
    output logic                                   o_reg_rvalid,
    input  wire logic                              i_ldo_a_good,
    input  wire logic                              i_ldo_b_good,
    input  wire logic                              i_total_expired,
    input  wire logic                              i_pre_expired,
    input  wire logic                              i_input_in_window,
    output pmic_ldo_charger_regs_pkg::level_t      o_ldo_a_output_level_select,
    output logic                                   o_ldo_a_enable,
    output logic                                   o_ldo_a_bleed_on,
    output logic                                   o_ldo_a_fault_irq_allow,
    output pmic_ldo_charger_regs_pkg::level_t      o_ldo_b_output_level_select,
    output logic                                   o_ldo_b_enable,
    output logic                                   o_ldo_b_bleed_on,
    output logic                                   o_ldo_b_fault_irq_allow,
    output logic                                   o_keepalive_a_enable,
    output logic                                   o_keepalive_b_enable,
    output logic                                   o_charge_suspend,
    output pmic_ldo_charger_regs_pkg::timer_limit_t o_total_timer_limit,
    output pmic_ldo_charger_regs_pkg::timer_limit_t o_precondition_timer_limit,
    output logic                                   o_charge_current_select,
    output logic                                   o_input_overvoltage_threshold_select,
    output logic                                   o_timeout_irq
);

    // ======================================================================
    // pin filtering
    logic [`PIN_COUNT-1:0] pins_raw, pin_s1_r, pin_s2_r, pin_s3_r;
    logic [`PIN_COUNT-1:0] pin_f_r, pin_f_prev_r;

    assign pins_raw = {i_input_in_window, i_pre_expired, i_total_expired,
                       i_ldo_b_good, i_ldo_a_good};

    // three-stage synchroniser; first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
        end else begin
            pin_s1_r <= pins_raw;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // a change counts only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < `PIN_COUNT; gi++) begin : g_pin_filter
            always_ff @(posedge i_clk) begin
                if (!i_rst_b) begin
                    pin_f_r[gi]      <= 1'b0;
                    pin_f_prev_r[gi] <= 1'b0;
                end else begin
                    if (pin_s2_r[gi] == pin_s3_r[gi]) begin
                        pin_f_r[gi] <= pin_s3_r[gi];
                    end
                    pin_f_prev_r[gi] <= pin_f_r[gi];
                end
            end
        end
    endgenerate

    logic in_window, total_rise, pre_rise;

    assign in_window  = pin_f_r[`PIN_INPUT_IN_WINDOW];
    assign total_rise = pin_f_r[`PIN_TOTAL_EXPIRED] & ~pin_f_prev_r[`PIN_TOTAL_EXPIRED];
    assign pre_rise   = pin_f_r[`PIN_PRE_EXPIRED] & ~pin_f_prev_r[`PIN_PRE_EXPIRED];

    // ======================================================================
    // write decode
    logic wr_a_level, wr_a_ctrl, wr_b_level, wr_b_ctrl, wr_keep;
    logic wr_chg, wr_irq_stat, wr_irq_ctrl, rd_irq_stat;

    assign wr_a_level  = i_reg_wr && (i_reg_addr == `LDO_A_LEVEL_ADDR);
    assign wr_a_ctrl   = i_reg_wr && (i_reg_addr == `LDO_A_CONTROL_ADDR);
    assign wr_b_level  = i_reg_wr && (i_reg_addr == `LDO_B_LEVEL_ADDR);
    assign wr_b_ctrl   = i_reg_wr && (i_reg_addr == `LDO_B_CONTROL_ADDR);
    assign wr_keep     = i_reg_wr && (i_reg_addr == `KEEPALIVE_ENABLES_ADDR);
    assign wr_chg      = i_reg_wr && (i_reg_addr == `CHARGER_CONTROL_ADDR);
    assign wr_irq_stat = i_reg_wr && (i_reg_addr == `CHARGER_IRQ_STATUS_ADDR);
    assign wr_irq_ctrl = i_reg_wr && (i_reg_addr == `CHARGER_IRQ_CONTROL_ADDR);
    assign rd_irq_stat = i_reg_rd && (i_reg_addr == `CHARGER_IRQ_STATUS_ADDR);

    // ======================================================================
    // regulator registers; only documented fields are stored
    logic ldo_a_bleed_r, ldo_b_bleed_r; // bleed setting; path drive also needs the enable clear
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_ldo_a_output_level_select <= `LEVEL_RESET;
            o_ldo_b_output_level_select <= `LEVEL_RESET;
        end else begin
            if (wr_a_level) begin
                o_ldo_a_output_level_select <= i_reg_wdata[`LEVEL_MSB:0];
            end
            if (wr_b_level) begin
                o_ldo_b_output_level_select <= i_reg_wdata[`LEVEL_MSB:0];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_ldo_a_enable          <= 1'b0;
            o_ldo_a_fault_irq_allow <= 1'b0;
            o_ldo_b_enable          <= 1'b0;
            o_ldo_b_fault_irq_allow <= 1'b0;
            ldo_a_bleed_r           <= 1'b0;
            ldo_b_bleed_r           <= 1'b0;
        end else begin
            if (wr_a_ctrl) begin
                o_ldo_a_enable          <= i_reg_wdata[`LDO_ENABLE_BIT];
                o_ldo_a_fault_irq_allow <= i_reg_wdata[`LDO_FAULT_ALLOW_BIT];
                ldo_a_bleed_r           <= i_reg_wdata[`LDO_BLEED_BIT];
            end
            if (wr_b_ctrl) begin
                o_ldo_b_enable          <= i_reg_wdata[`LDO_ENABLE_BIT];
                o_ldo_b_fault_irq_allow <= i_reg_wdata[`LDO_FAULT_ALLOW_BIT];
                ldo_b_bleed_r           <= i_reg_wdata[`LDO_BLEED_BIT];
            end
        end
    end

    // discharge path follows shut-down one cycle late, so it can overlap the first enabled cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_ldo_a_bleed_on <= 1'b0;
            o_ldo_b_bleed_on <= 1'b0;
        end else begin
            o_ldo_a_bleed_on <= ldo_a_bleed_r & ~o_ldo_a_enable;
            o_ldo_b_bleed_on <= ldo_b_bleed_r & ~o_ldo_b_enable;
        end
    end

    // ======================================================================
    // keep-alive and charger control
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_keepalive_a_enable <= 1'b0;
            o_keepalive_b_enable <= 1'b0;
        end else if (wr_keep) begin
            o_keepalive_a_enable <= i_reg_wdata[`KEEPALIVE_A_BIT];
            o_keepalive_b_enable <= i_reg_wdata[`KEEPALIVE_B_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_charge_suspend                     <= 1'b0;
            o_total_timer_limit                  <= `TIMER_LIMIT_RESET;
            o_precondition_timer_limit           <= `TIMER_LIMIT_RESET;
            o_charge_current_select              <= 1'b0;
            o_input_overvoltage_threshold_select <= 1'b0;
        end else if (wr_chg) begin
            o_charge_suspend <= i_reg_wdata[`CHG_SUSPEND_BIT];
            o_total_timer_limit <=
                i_reg_wdata[`CHG_TOTAL_LIMIT_MSB:`CHG_TOTAL_LIMIT_LSB];
            o_precondition_timer_limit <=
                i_reg_wdata[`CHG_PRE_LIMIT_MSB:`CHG_PRE_LIMIT_LSB];
            o_charge_current_select <= i_reg_wdata[`CHG_CURRENT_BIT];
            o_input_overvoltage_threshold_select <= i_reg_wdata[`CHG_OVP_BIT];
        end
    end

    // ======================================================================
    // charge time-out interrupt
    logic timeout_arm_r, total_timeout_irq_enable_r, precondition_timeout_irq_enable_r;
    logic timeout_hit, timeout_clear;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            timeout_arm_r                     <= 1'b0;
            total_timeout_irq_enable_r        <= 1'b0;
            precondition_timeout_irq_enable_r <= 1'b0;
        end else begin
            if (wr_irq_stat) begin
                timeout_arm_r <= i_reg_wdata[`TIMEOUT_STATUS_BIT];
            end
            if (wr_irq_ctrl) begin
                total_timeout_irq_enable_r <= i_reg_wdata[`TOTAL_TIMEOUT_EN_BIT];
                precondition_timeout_irq_enable_r <= i_reg_wdata[`PRE_TIMEOUT_EN_BIT];
            end
        end
    end

    // expiry only counts with the charger input inside its valid window
    assign timeout_hit = timeout_arm_r & in_window &
                         ((total_rise & total_timeout_irq_enable_r) |
                          (pre_rise & precondition_timeout_irq_enable_r));
    assign timeout_clear = rd_irq_stat | (wr_irq_stat & ~i_reg_wdata[`TIMEOUT_STATUS_BIT]);

    // sticky until read or a zero write to the status bit; a hit in the clearing cycle is kept
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_timeout_irq <= 1'b0;
        end else if (timeout_hit) begin
            o_timeout_irq <= 1'b1;
        end else if (timeout_clear) begin
            o_timeout_irq <= 1'b0;
        end
    end

    // ======================================================================
    // read path; reserved and unmapped positions read zero
    pmic_ldo_charger_regs_pkg::reg_byte_t rd_mux;

    always_comb begin
        rd_mux = `BYTE_ZERO;
        if (i_reg_addr == `LDO_A_LEVEL_ADDR) begin
            rd_mux[`LEVEL_MSB:0] = o_ldo_a_output_level_select;
        end else if (i_reg_addr == `LDO_A_CONTROL_ADDR) begin
            rd_mux[`LDO_ENABLE_BIT]      = o_ldo_a_enable;
            rd_mux[`LDO_BLEED_BIT]       = ldo_a_bleed_r;
            rd_mux[`LDO_FAULT_ALLOW_BIT] = o_ldo_a_fault_irq_allow;
            rd_mux[`LDO_POWER_GOOD_BIT]  = pin_f_r[`PIN_LDO_A_GOOD];
        end else if (i_reg_addr == `LDO_B_LEVEL_ADDR) begin
            rd_mux[`LEVEL_MSB:0] = o_ldo_b_output_level_select;
        end else if (i_reg_addr == `LDO_B_CONTROL_ADDR) begin
            rd_mux[`LDO_ENABLE_BIT]      = o_ldo_b_enable;
            rd_mux[`LDO_BLEED_BIT]       = ldo_b_bleed_r;
            rd_mux[`LDO_FAULT_ALLOW_BIT] = o_ldo_b_fault_irq_allow;
            rd_mux[`LDO_POWER_GOOD_BIT]  = pin_f_r[`PIN_LDO_B_GOOD];
        end else if (i_reg_addr == `KEEPALIVE_ENABLES_ADDR) begin
            rd_mux[`KEEPALIVE_A_BIT] = o_keepalive_a_enable;
            rd_mux[`KEEPALIVE_B_BIT] = o_keepalive_b_enable;
        end else if (i_reg_addr == `CHARGER_CONTROL_ADDR) begin
            rd_mux[`CHG_SUSPEND_BIT] = o_charge_suspend;
            rd_mux[`CHG_TOTAL_LIMIT_MSB:`CHG_TOTAL_LIMIT_LSB] = o_total_timer_limit;
            rd_mux[`CHG_PRE_LIMIT_MSB:`CHG_PRE_LIMIT_LSB] = o_precondition_timer_limit;
            rd_mux[`CHG_CURRENT_BIT] = o_charge_current_select;
            rd_mux[`CHG_OVP_BIT]     = o_input_overvoltage_threshold_select;
        end else if (i_reg_addr == `CHARGER_IRQ_STATUS_ADDR) begin
            rd_mux[`TIMEOUT_STATUS_BIT] = o_timeout_irq & in_window;
        end else if (i_reg_addr == `CHARGER_IRQ_CONTROL_ADDR) begin
            rd_mux[`TOTAL_TIMEOUT_EN_BIT] = total_timeout_irq_enable_r;
            rd_mux[`PRE_TIMEOUT_EN_BIT]   = precondition_timeout_irq_enable_r;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_reg_rdata  <= `BYTE_ZERO;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rd_mux;
            end
        end
    end

    // ======================================================================
    // checks
    a_level_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        wr_a_level |=> o_ldo_a_output_level_select == $past(i_reg_wdata[5:0]))
        else $error("level field not taken from write");

    a_enable_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        wr_b_ctrl |=> o_ldo_b_enable == $past(i_reg_wdata[7]))
        else $error("regulator enable not taken from write");

    a_bleed_off_when_on: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_ldo_a_enable ##1 o_ldo_a_enable |-> !o_ldo_a_bleed_on)
        else $error("discharge path on while regulator runs");

    a_fault_allow_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !wr_a_ctrl |=> $stable(o_ldo_a_fault_irq_allow))
        else $error("fault allow changed without a write");

    a_power_good_read: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_reg_rd && i_reg_addr == 8'h71) |=> o_reg_rdata[0] == $past(pin_f_r[0]))
        else $error("power-good readback wrong");

    a_keepalive_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        wr_keep |=> o_keepalive_a_enable == $past(i_reg_wdata[7])
                 && o_keepalive_b_enable == $past(i_reg_wdata[6]))
        else $error("keep-alive enables not taken");

    a_charger_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        wr_chg |=> o_total_timer_limit == $past(i_reg_wdata[5:4])
                && o_precondition_timer_limit == $past(i_reg_wdata[3:2])
                && o_charge_suspend == $past(i_reg_wdata[7]))
        else $error("charger control fields not taken");

    a_timeout_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        timeout_hit |=> o_timeout_irq [*1] ##0 (o_timeout_irq || timeout_clear))
        else $error("time-out interrupt not raised");

    a_timeout_window: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (o_timeout_irq && !$past(o_timeout_irq)) |-> $past(in_window))
        else $error("time-out raised outside input window");

    a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_reg_rvalid && $past(i_reg_addr) == 8'h91 |-> o_reg_rdata[5:0] == 6'h00)
        else $error("reserved bits not zero");

endmodule : pmic_ldo_charger_regs

// >>> pmic_ldo_charger_regs_map.svh
/*
  Offsets, field positions, reset values and pin-filter figures for the
  regulator and charger control register bank.
  Assumes byte-wide registers addressed by an 8-bit register number.
*/
`ifndef PMIC_LDO_CHARGER_REGS_MAP_SVH
`define PMIC_LDO_CHARGER_REGS_MAP_SVH

// ==========================================================================
// register offsets
`define LDO_A_LEVEL_ADDR        8'h70
`define LDO_A_CONTROL_ADDR      8'h71
`define LDO_B_LEVEL_ADDR        8'h80
`define LDO_B_CONTROL_ADDR      8'h81
`define KEEPALIVE_ENABLES_ADDR  8'h91
`define CHARGER_CONTROL_ADDR    8'ha1
`define CHARGER_IRQ_STATUS_ADDR 8'ha8
`define CHARGER_IRQ_CONTROL_ADDR 8'ha9

// ==========================================================================
// field positions
`define LEVEL_MSB               5
`define LDO_ENABLE_BIT          7
`define LDO_BLEED_BIT           2
`define LDO_FAULT_ALLOW_BIT     1
`define LDO_POWER_GOOD_BIT      0
`define KEEPALIVE_A_BIT         7
`define KEEPALIVE_B_BIT         6
`define CHG_SUSPEND_BIT         7
`define CHG_TOTAL_LIMIT_MSB     5
`define CHG_TOTAL_LIMIT_LSB     4
`define CHG_PRE_LIMIT_MSB       3
`define CHG_PRE_LIMIT_LSB       2
`define CHG_CURRENT_BIT         1
`define CHG_OVP_BIT             0
`define TIMEOUT_STATUS_BIT      7
`define TOTAL_TIMEOUT_EN_BIT    7
`define PRE_TIMEOUT_EN_BIT      3

// ==========================================================================
// reset values
`define LEVEL_RESET             6'h00
`define TIMER_LIMIT_RESET       2'h0
`define BYTE_ZERO               8'h00

// ==========================================================================
// pin inputs
`define PIN_COUNT               5
`define PIN_LDO_A_GOOD          0
`define PIN_LDO_B_GOOD          1
`define PIN_TOTAL_EXPIRED       2
`define PIN_PRE_EXPIRED         3
`define PIN_INPUT_IN_WINDOW     4

`endif

// >>> pmic_ldo_charger_regs_pkg.sv
/*
  Types shared by the regulator and charger register bank.
  Assumes the constants header supplies offsets and fields.
*/
package pmic_ldo_charger_regs_pkg;

    typedef logic [7:0] reg_byte_t;
    typedef logic [5:0] level_t;
    typedef logic [1:0] timer_limit_t;

endpackage : pmic_ldo_charger_regs_pkg

// >>> tb.sv
/*
  Self-checking bench for the regulator and charger register bank.
  Assumes the strobe register port and the power-good model beside it.
*/
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       i_clk, i_rst_b, i_reg_wr, i_reg_rd, o_reg_rvalid;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic       i_ldo_a_good, i_ldo_b_good, i_total_expired, i_pre_expired;
    logic       i_input_in_window, o_timeout_irq;
    logic       o_ldo_a_enable, o_ldo_a_bleed_on, o_ldo_a_fault_irq_allow;
    logic       o_ldo_b_enable, o_ldo_b_bleed_on, o_ldo_b_fault_irq_allow;
    logic       o_keepalive_a_enable, o_keepalive_b_enable, o_charge_suspend;
    logic       o_charge_current_select, o_input_overvoltage_threshold_select;
    pmic_ldo_charger_regs_pkg::level_t       o_ldo_a_output_level_select;
    pmic_ldo_charger_regs_pkg::level_t       o_ldo_b_output_level_select;
    pmic_ldo_charger_regs_pkg::timer_limit_t o_total_timer_limit;
    pmic_ldo_charger_regs_pkg::timer_limit_t o_precondition_timer_limit;
    int         bad_count   = 0;
    int         checks_done = 0;
    logic [7:0] outs_a, outs_b, outs_chg;
    // ======================================================
    // packed views of the pin outputs for byte compares
    assign outs_a   = {5'h0, o_ldo_a_enable, o_ldo_a_bleed_on, o_ldo_a_fault_irq_allow};
    assign outs_b   = {5'h0, o_ldo_b_enable, o_ldo_b_bleed_on, o_ldo_b_fault_irq_allow};
    assign outs_chg = {o_charge_suspend, 1'b0, o_total_timer_limit,
                       o_precondition_timer_limit, o_charge_current_select,
                       o_input_overvoltage_threshold_select};

    pmic_ldo_charger_regs uut (.i_clk, .i_rst_b, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
        .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_ldo_a_good, .i_ldo_b_good,
        .i_total_expired, .i_pre_expired, .i_input_in_window,
        .o_ldo_a_output_level_select, .o_ldo_a_enable, .o_ldo_a_bleed_on,
        .o_ldo_a_fault_irq_allow, .o_ldo_b_output_level_select, .o_ldo_b_enable,
        .o_ldo_b_bleed_on, .o_ldo_b_fault_irq_allow, .o_keepalive_a_enable,
        .o_keepalive_b_enable, .o_charge_suspend, .o_total_timer_limit,
        .o_precondition_timer_limit, .o_charge_current_select,
        .o_input_overvoltage_threshold_select, .o_timeout_irq);

    ldo_good_model pg (.i_clk, .i_rst_b, .i_en_a(o_ldo_a_enable), .i_en_b(o_ldo_b_enable),
        .o_good_a(i_ldo_a_good), .o_good_b(i_ldo_b_good));

    task automatic complete_run();
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // ======================================================
    // bus cycles: strobe held one cycle, changed at falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_reg_addr  = a;
        i_reg_wdata = d;
        i_reg_wr    = 1'b1;
        @(negedge i_clk);
        i_reg_wr    = 1'b0;
        i_reg_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_clk);
        i_reg_addr = a;
        i_reg_rd   = 1'b1;
        @(negedge i_clk);
        i_reg_rd   = 1'b0;
        chk("rvalid", 8'h01, {7'h0, o_reg_rvalid});
        chk($sformatf("reg %h", a), exp, o_reg_rdata);
    endtask : rd

    // power-good pins settle, then the pin filter needs a few edges
    task automatic settle(input logic a, input logic b);
        int k;
        for (k = 0; k < 20 && {i_ldo_a_good, i_ldo_b_good} !== {a, b}; k++) @(negedge i_clk);
        if (k == 20) begin
            bad_count++;
            complete_run();
        end
        repeat (5) @(negedge i_clk);
    endtask : settle

    task automatic pulse(input logic tot);
        @(negedge i_clk);
        if (tot) i_total_expired = 1'b1;
        else i_pre_expired = 1'b1;
        repeat (6) @(negedge i_clk);
        i_total_expired = 1'b0;
        i_pre_expired   = 1'b0;
    endtask : pulse

    task automatic expect_irq(input logic exp);
        int k;
        for (k = 0; k < 12 && o_timeout_irq !== 1'b1; k++) @(negedge i_clk);
        chk("irq", {7'h0, exp}, {7'h0, o_timeout_irq});
        if (exp && k == 12) complete_run();
    endtask : expect_irq

    // ======================================================
    // scenarios
    task automatic t_level();
        chk("reset outs", 8'h00, outs_a | outs_b | outs_chg);
        rd(8'h70, 8'h00);
        wr(8'h70, 8'hff);
        chk("level a", 8'h3f, {2'h0, o_ldo_a_output_level_select});
        rd(8'h70, 8'h3f);
        wr(8'h80, 8'hea);
        chk("level b", 8'h2a, {2'h0, o_ldo_b_output_level_select});
        rd(8'h80, 8'h2a);
        wr(8'h72, 8'hff);
        rd(8'h72, 8'h00);
    endtask : t_level

    task automatic t_ldo(input logic b);
        logic [7:0] a;
        a = b ? 8'h81 : 8'h71;
        wr(a, 8'hfe);
        @(negedge i_clk);
        chk("ldo on", 8'h05, b ? outs_b : outs_a);
        settle(!b, b);
        rd(a, 8'h87);
        wr(a, 8'h04);
        @(negedge i_clk);
        chk("ldo off", 8'h02, b ? outs_b : outs_a);
        settle(1'b0, 1'b0);
        rd(a, 8'h04);
    endtask : t_ldo

    task automatic t_keep_chg();
        wr(8'h91, 8'hff);
        chk("keep", 8'h03, {6'h0, o_keepalive_a_enable, o_keepalive_b_enable});
        rd(8'h91, 8'hc0);
        wr(8'h91, 8'h40);
        chk("keep", 8'h01, {6'h0, o_keepalive_a_enable, o_keepalive_b_enable});
        wr(8'ha1, 8'hff);
        chk("chg", 8'hbf, outs_chg);
        rd(8'ha1, 8'hbf);
        wr(8'ha1, 8'h96);
        chk("chg", 8'h96, outs_chg);
        rd(8'ha1, 8'h96);
        wr(8'ha1, 8'h00);
        chk("chg", 8'h00, outs_chg);
        wr(8'ha1, 8'h09);
        rd(8'ha1, 8'h09);
    endtask : t_keep_chg

    task automatic t_irq();
        wr(8'ha9, 8'h88);
        rd(8'ha9, 8'h88);
        wr(8'ha8, 8'h80);
        pulse(1'b1);
        expect_irq(1'b1);
        rd(8'ha8, 8'h80);
        chk("irq clr", 8'h00, {7'h0, o_timeout_irq});
        wr(8'ha9, 8'h08);
        pulse(1'b1);
        expect_irq(1'b0);
        pulse(1'b0);
        expect_irq(1'b1);
        i_input_in_window = 1'b0;
        repeat (8) @(negedge i_clk);
        rd(8'ha8, 8'h00);
        pulse(1'b0);
        expect_irq(1'b0);
        i_input_in_window = 1'b1;
        wr(8'ha8, 8'h00);
        repeat (8) @(negedge i_clk);
        pulse(1'b0);
        expect_irq(1'b0);
    endtask : t_irq

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    initial begin
        i_rst_b           = 1'b0;
        i_reg_wr          = 1'b0;
        i_reg_rd          = 1'b0;
        i_reg_addr        = 8'h00;
        i_reg_wdata       = 8'h00;
        i_total_expired   = 1'b0;
        i_pre_expired     = 1'b0;
        i_input_in_window = 1'b1;
        repeat (2) @(negedge i_clk);
        i_rst_b = 1'b1;
        repeat (4) @(negedge i_clk);
        t_level();
        t_ldo(1'b0);
        t_ldo(1'b1);
        t_keep_chg();
        t_irq();
        complete_run();
    end
endmodule : tb
